/* File: rtl/tmr_consts.vh */
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// read addresses
`define TMR_RD_LOCAL        8'h00
`define TMR_RD_REMOTE_HI    8'h01
`define TMR_RD_STATUS       8'h02
`define TMR_RD_SETUP        8'h03
`define TMR_RD_PACE         8'h04
`define TMR_RD_LOC_UPPER    8'h05
`define TMR_RD_LOC_LOWER    8'h06
`define TMR_RD_REM_UPPER_HI 8'h07
`define TMR_RD_REM_LOWER_HI 8'h08
`define TMR_RD_REMOTE_LO    8'h10
`define TMR_RD_SPARE_A      8'h19
`define TMR_RD_MAKER        8'hfe
`define TMR_RD_REVISION     8'hff

// write addresses
`define TMR_WR_SETUP        8'h09
`define TMR_WR_PACE         8'h0a
`define TMR_WR_LOC_UPPER    8'h0b
`define TMR_WR_LOC_LOWER    8'h0c
`define TMR_WR_REM_UPPER_HI 8'h0d
`define TMR_WR_REM_LOWER_HI 8'h0e
`define TMR_WR_SINGLE_SHOT  8'h0f

// addresses shared by read and write
`define TMR_RW_TRIM_HI      8'h11
`define TMR_RW_TRIM_LO      8'h12
`define TMR_RW_REM_UPPER_LO 8'h13
`define TMR_RW_REM_LOWER_LO 8'h14

// field positions
`define TMR_SETUP_MASK_BIT  7
`define TMR_SETUP_STANDBY_PIN_BIT  6
`define TMR_STAT_BUSY_BIT   7
`define TMR_PACE_CODE_MAX   3'h7

// reset values
`define TMR_RST_READING_HI  8'h80
`define TMR_RST_SETUP       2'h0
`define TMR_RST_PACE        8'h02
`define TMR_RST_UPPER       8'h7f
`define TMR_RST_LOWER_HI    8'hc9
`define TMR_RST_ZERO        8'h00

// fastest conversion interval (code 7) and its count at the core clock
`define TMR_CLK_MHZ         100
`define TMR_FAST_PERIOD_MS  125
`define TMR_FAST_PERIOD_CYC (`TMR_FAST_PERIOD_MS * 1000 * `TMR_CLK_MHZ)

`endif

/* File: rtl/tmr_regfile.v */
// Overview of operation
// (R1) read and write addresses decode separately
// (R2) host never writes above address 0x14
// (R3) first write byte loads the register pointer
// (R4) readings loaded by converter, bus read-only
// (R5) offset is 11-bit signed, hi/lo left-justified
// (R6) offset added to each remote result, resets zero
// (R7) offset overflow saturates remote reading
// (R8) power-on values loaded into all registers
// (R9) write to 0F starts one conversion
// (R10) status bit 7 shows converter busy
// (R11) status bits 6..3 flag limit trips
// (R12) status bit 2 flags open remote sensor
// (R13) any flag sets alarm latch, alarm low
// (R14) status read clears only flags whose cause gone
// (R15) flags stay set until read or reset
// (R16) alert-response read releases latch when all clear
// (R17) setup bit 6 selects run or standby
// (R18) low standby pin also forces standby
// (R19) readings held while in standby
// (R20) setup bit 7 masks alarm output
// (R21) high trips strictly above, low strictly below
// (R22) one-shot in standby converts once, returns
// (R23) pace code 0..7 doubles rate each step
// (R24) lsb is 1/8 degree, fraction in bits 7..5
// (R25) conversion end updates readings, flags, busy

`include "tmr_consts.vh"

module tmr_regfile #(
  parameter        FAST_PERIOD_CYC = `TMR_FAST_PERIOD_CYC, // interval at pace code 7
  parameter [7:0]  MAKER_CODE      = 8'h5a,                // arbitrary value
  parameter [7:0]  REVISION_CODE   = 8'h10                 // arbitrary value
) (
  input  wire        clk,            // core clock, 100 MHz
  input  wire        reset,          // async reset, active high
  input  wire        ptr_wr_stb,     // first byte of a bus write is on wr_byte
  input  wire        data_wr_stb,    // data byte of a bus write is on wr_byte
  input  wire [7:0]  wr_byte,        // byte written by the bus host
  input  wire        rd_stb,         // bus host reads register at pointer
  output reg  [7:0]  rd_byte_r,      // read answer, valid cycle after rd_stb
  input  wire        alert_resp_stb, // alert-response read of device address
  input  wire        standby_pin,    // external standby, active low, async
  output reg         conv_start_r,   // one-cycle request to the converter
  input  wire        conv_done,      // converter result strobe
  input  wire [7:0]  local_meas,     // local result, whole degrees
  input  wire [10:0] remote_meas,    // remote result, 1/8 degree units
  input  wire        remote_open,    // remote diode open, valid with conv_done
  output reg         alarm_out_n_r   // alarm output, active low
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // register file
  reg  [7:0]  ptr_r;
  reg  [7:0]  local_r;
  reg  [7:0]  remote_hi_r;
  reg  [7:0]  remote_lo_r;
  reg  [1:0]  setup_r;          // {mask, standby}
  reg  [7:0]  pace_r;
  reg  [7:0]  loc_upper_r;
  reg  [7:0]  loc_lower_r;
  reg  [7:0]  rem_upper_hi_r;
  reg  [7:0]  rem_lower_hi_r;
  reg  [7:0]  rem_upper_lo_r;
  reg  [7:0]  rem_lower_lo_r;
  reg  [7:0]  trim_hi_r;
  reg  [7:0]  trim_lo_r;

  // status and alarm
  reg  [4:0]  flags_r;          // {l_over, l_under, r_over, r_under, open}
  reg  [4:0]  cause_r;          // conditions seen at the last conversion end
  reg         alarm_latch_r;

  // conversion control
  reg  [1:0]  state_r;
  reg  [31:0] pace_cnt_r;
  reg         shot_pend_r;
  reg         standby_pin_meta_r;
  reg         standby_pin_sync_r;

  reg  [1:0]  state_nxt;
  reg  [4:0]  flags_nxt;
  reg  [7:0]  rd_byte_nxt;

  wire        standby;
  wire        pace_tick;
  wire        start_conv;
  wire        result_take;
  wire        status_rd;
  wire        shot_wr;
  wire [10:0] remote_adj;
  wire [4:0]  cause_now;
  wire [31:0] interval;

  // interval for a pace code: slowest at code 0, doubling up to code 7
  function [31:0] pace_interval;
    input [2:0] code;
    begin
      pace_interval = FAST_PERIOD_CYC[31:0] << (`TMR_PACE_CODE_MAX - code); // (R23)
    end
  endfunction

  // remote sum with offset, clamped to the signed 8.3 range
  function [10:0] add_trim;
    input [10:0] meas;
    input [10:0] trim;
    reg   [12:0] sum;
    begin
      sum = {2'b00, meas} + {{2{trim[10]}}, trim}; // (R6)
      if (!sum[12] && (sum[11] || sum[10])) begin
        add_trim = 11'h3ff; // (R7)
      end else if (sum[12] && !(sum[11] && sum[10])) begin
        add_trim = 11'h400; // (R7)
      end else begin
        add_trim = sum[10:0];
      end
    end
  endfunction

  // strict signed comparison on 11-bit values
  function greater;
    input [10:0] a;
    input [10:0] b;
    begin
      greater = $signed(a) > $signed(b); // (R21)
    end
  endfunction

  // low-byte fraction: only bits 7..5 are kept, the rest read back zero
  function [7:0] frac_only;
    input [7:0] b;
    begin
      frac_only = {b[7:5], 5'b00000}; // (R24)
    end
  endfunction

  // whole-degree byte widened to the 8.3 compare format
  function [10:0] whole_q;
    input [7:0] w;
    begin
      whole_q = {w, 3'b000};
    end
  endfunction

  // high byte plus low-byte fraction joined into one 8.3 value
  function [10:0] pair_q;
    input [7:0] hi;
    input [7:0] lo;
    begin
      pair_q = {hi, lo[7:5]}; // (R5)
    end
  endfunction

  // two-flop synchroniser for the standby pin; idles high (running)
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      standby_pin_meta_r <= 1'b1;
      standby_pin_sync_r <= 1'b1;
    end else begin
      standby_pin_meta_r <= standby_pin;
      standby_pin_sync_r <= standby_pin_meta_r;
    end
  end

  // either the setup bit or a low pin puts the block in standby
  assign standby = setup_r[0] | ~standby_pin_sync_r; // (R17) (R18)

  // bus strobes decoded against the pointer
  assign shot_wr   = data_wr_stb & (ptr_r == `TMR_WR_SINGLE_SHOT); // (R9)
  assign status_rd = rd_stb & (ptr_r == `TMR_RD_STATUS);

  // pacing counter; stands at zero in standby so a return to run waits a full interval
  assign interval  = pace_interval(pace_r[2:0]);
  assign pace_tick = (pace_cnt_r >= interval - 32'd1);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pace_cnt_r <= 32'h0000_0000;
    end else if (standby || start_conv) begin
      pace_cnt_r <= 32'h0000_0000; // (R17)
    end else if (!pace_tick) begin
      pace_cnt_r <= pace_cnt_r + 32'd1;
    end
  end

  // a one-shot waits until the converter is idle; a write in the same cycle wins
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      shot_pend_r <= 1'b0;
    end else begin
      shot_pend_r <= shot_wr | (shot_pend_r & ~start_conv); // (R9) (R22)
    end
  end

  assign start_conv  = state_r[0] & (shot_pend_r | (~standby & pace_tick)); // (R22)
  assign result_take = state_r[1] & conv_done; // (R25)

  // conversion sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_conv) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          state_nxt = ST_IDLE; // (R25)
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r      <= ST_IDLE;
      conv_start_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      conv_start_r <= start_conv;
    end
  end

  // offset applied to the fresh remote result; fraction sits in low byte bits 7..5
  assign remote_adj = add_trim(remote_meas, pair_q(trim_hi_r, trim_lo_r)); // (R5) (R24)

  // limit and sensor conditions of the fresh result
  assign cause_now[4] = greater(whole_q(local_meas), whole_q(loc_upper_r)); // (R11) (R21)
  assign cause_now[3] = greater(whole_q(loc_lower_r), whole_q(local_meas)); // (R11) (R21)
  assign cause_now[2] = greater(remote_adj, pair_q(rem_upper_hi_r, rem_upper_lo_r)); // (R11)
  assign cause_now[1] = greater(pair_q(rem_lower_hi_r, rem_lower_lo_r), remote_adj); // (R11)
  assign cause_now[0] = remote_open; // (R12)

  // readings change only at a conversion end, so standby holds them
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      local_r     <= `TMR_RST_READING_HI; // (R8)
      remote_hi_r <= `TMR_RST_READING_HI;
      remote_lo_r <= `TMR_RST_ZERO;
      cause_r     <= 5'h00;
    end else if (result_take) begin
      local_r     <= local_meas; // (R4) (R19)
      remote_hi_r <= remote_adj[10:3];
      remote_lo_r <= {remote_adj[2:0], 5'b00000}; // (R24)
      cause_r     <= cause_now; // (R25)
    end
  end

  // sticky flags: a read drops only those whose cause is gone; a new trip wins
  always @* begin
    flags_nxt = flags_r;
    // cause_r is the verdict of the last finished conversion, so a read between
    // conversions cannot drop a flag whose limit is still exceeded
    if (status_rd) begin
      flags_nxt = flags_r & cause_r; // (R14) (R15)
    end
    if (result_take) begin
      flags_nxt = flags_nxt | cause_now;
    end
  end

  // alarm latch set by any flag, released only by an alert-response with all clear
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_r       <= 5'h00;
      alarm_latch_r <= 1'b0;
      alarm_out_n_r <= 1'b1;
    end else begin
      flags_r <= flags_nxt;
      if (|flags_nxt) begin
        alarm_latch_r <= 1'b1; // (R13)
      end else if (alert_resp_stb && !(|cause_r)) begin
        alarm_latch_r <= 1'b0; // (R16)
      end
      // the mask gates only the pin; the latch keeps following the flags
      alarm_out_n_r <= ~(alarm_latch_r & ~setup_r[1]); // (R13) (R20)
    end
  end

  // pointer and writable registers; first byte always goes to the pointer
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_r          <= `TMR_RST_ZERO;
      setup_r        <= `TMR_RST_SETUP; // (R8)
      pace_r         <= `TMR_RST_PACE;
      loc_upper_r    <= `TMR_RST_UPPER;
      loc_lower_r    <= `TMR_RST_LOWER_HI;
      rem_upper_hi_r <= `TMR_RST_UPPER;
      rem_lower_hi_r <= `TMR_RST_LOWER_HI;
      rem_upper_lo_r <= `TMR_RST_ZERO;
      rem_lower_lo_r <= `TMR_RST_ZERO;
      trim_hi_r      <= `TMR_RST_ZERO; // (R6)
      trim_lo_r      <= `TMR_RST_ZERO;
    end else if (ptr_wr_stb) begin
      ptr_r <= wr_byte; // (R3)
    end else if (data_wr_stb) begin
      // write decode; read-only addresses are simply not written (R1)
      case (ptr_r)
        `TMR_WR_SETUP: begin
          setup_r <= {wr_byte[`TMR_SETUP_MASK_BIT], wr_byte[`TMR_SETUP_STANDBY_PIN_BIT]}; // (R17)
        end
        `TMR_WR_PACE: begin
          pace_r <= wr_byte; // (R23)
        end
        `TMR_WR_LOC_UPPER: begin
          loc_upper_r <= wr_byte;
        end
        `TMR_WR_LOC_LOWER: begin
          loc_lower_r <= wr_byte;
        end
        `TMR_WR_REM_UPPER_HI: begin
          rem_upper_hi_r <= wr_byte;
        end
        `TMR_WR_REM_LOWER_HI: begin
          rem_lower_hi_r <= wr_byte;
        end
        `TMR_RW_TRIM_HI: begin
          trim_hi_r <= wr_byte; // (R5)
        end
        `TMR_RW_TRIM_LO: begin
          trim_lo_r <= frac_only(wr_byte); // (R5)
        end
        `TMR_RW_REM_UPPER_LO: begin
          rem_upper_lo_r <= frac_only(wr_byte);
        end
        `TMR_RW_REM_LOWER_LO: begin
          rem_lower_lo_r <= frac_only(wr_byte);
        end
        default: begin
          // one-shot and unmapped addresses store nothing (R2) (R9)
          ptr_r <= ptr_r;
        end
      endcase
    end
  end

  // read decode; write-only and unmapped addresses answer zero
  always @* begin
    rd_byte_nxt = rd_byte_r;
    if (rd_stb) begin
      case (ptr_r)
        `TMR_RD_LOCAL:        rd_byte_nxt = local_r; // (R4)
        `TMR_RD_REMOTE_HI:    rd_byte_nxt = remote_hi_r;
        `TMR_RD_REMOTE_LO:    rd_byte_nxt = remote_lo_r;
        `TMR_RD_STATUS:       rd_byte_nxt = {state_r[1], flags_r, 2'b00}; // (R10) (R11)
        `TMR_RD_SETUP:        rd_byte_nxt = {setup_r, 6'b000000};
        `TMR_RD_PACE:         rd_byte_nxt = pace_r;
        `TMR_RD_LOC_UPPER:    rd_byte_nxt = loc_upper_r;
        `TMR_RD_LOC_LOWER:    rd_byte_nxt = loc_lower_r;
        `TMR_RD_REM_UPPER_HI: rd_byte_nxt = rem_upper_hi_r;
        `TMR_RD_REM_LOWER_HI: rd_byte_nxt = rem_lower_hi_r;
        `TMR_RW_TRIM_HI:      rd_byte_nxt = trim_hi_r;
        `TMR_RW_TRIM_LO:      rd_byte_nxt = trim_lo_r;
        `TMR_RW_REM_UPPER_LO: rd_byte_nxt = rem_upper_lo_r;
        `TMR_RW_REM_LOWER_LO: rd_byte_nxt = rem_lower_lo_r;
        `TMR_RD_MAKER:        rd_byte_nxt = MAKER_CODE;
        `TMR_RD_REVISION:     rd_byte_nxt = REVISION_CODE;
        default:              rd_byte_nxt = `TMR_RST_ZERO; // (R1)
      endcase
    end
  end

  // answer byte held until the next read
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_byte_r <= `TMR_RST_ZERO;
    end else begin
      rd_byte_r <= rd_byte_nxt;
    end
  end

endmodule // tmr_regfile

/* File: verif/tmr_regfile_props.sv */
module tmr_props (
  input logic       clk,            // core clock
  input logic       reset,          // async reset
  input logic       ptr_wr_stb,     // pointer byte
  input logic       data_wr_stb,    // data byte
  input logic [7:0] wr_byte,        // write byte
  input logic       rd_stb,         // read strobe
  input logic [7:0] rd_byte_r,      // read answer
  input logic       alert_resp_stb, // alert response
  input logic       conv_start_r,   // start pulse
  input logic       conv_done,      // result strobe
  input logic       remote_open,    // open sensor
  input logic       alarm_out_n_r   // alarm, low active
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ptr_r;
  logic       mask_r;
  logic       busy_r;
  logic       busy_now;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // shadow pointer, mask and busy; busy_now covers the edge where the start lands
  assign busy_now = busy_r | conv_start_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_r  <= 8'h00;
      mask_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      if (ptr_wr_stb) ptr_r <= wr_byte;
      if (data_wr_stb && !ptr_wr_stb && ptr_r == 8'h09) mask_r <= wr_byte[7];
      busy_r <= conv_start_r | (busy_r & ~conv_done);
    end
  end
  chk_start_one_cycle: assert property (conv_start_r |=> !conv_start_r)
    else $error("start pulse too long");
  chk_no_restart: assert property (conv_start_r |-> !busy_r)
    else $error("start while busy");
  chk_blank_reads: assert property (rd_stb && (ptr_r == 8'h19 ||
    (ptr_r >= 8'h09 && ptr_r <= 8'h0f)) |=> rd_byte_r == 8'h00)
    else $error("unreadable address not zero");
  chk_status_spare: assert property (rd_stb && ptr_r == 8'h02 |=> rd_byte_r[1:0] == 2'h0)
    else $error("status spare bits set");
  chk_busy_bit: assert property (rd_stb && ptr_r == 8'h02 |=> rd_byte_r[7] == $past(busy_now))
    else $error("busy bit wrong");
  chk_shot_starts: assert property (data_wr_stb && !ptr_wr_stb && ptr_r == 8'h0f
    |-> ##[1:40] conv_start_r)
    else $error("one-shot gave no start");
  chk_open_alarm: assert property (conv_done && busy_r && remote_open && !mask_r
    |-> ##3 !alarm_out_n_r)
    else $error("open sensor raised no alarm");
  chk_alarm_release: assert property ($rose(alarm_out_n_r)
    |-> $past(alert_resp_stb, 2) || mask_r)
    else $error("alarm released without alert response");
  chk_mask_gate: assert property (mask_r && $past(mask_r) |-> alarm_out_n_r)
    else $error("masked alarm driven");
endmodule // tmr_props

bind tmr_regfile tmr_props u_tmr_props (.clk(clk), .reset(reset), .ptr_wr_stb(ptr_wr_stb),
  .data_wr_stb(data_wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb), .rd_byte_r(rd_byte_r),
  .alert_resp_stb(alert_resp_stb), .conv_start_r(conv_start_r), .conv_done(conv_done),
  .remote_open(remote_open), .alarm_out_n_r(alarm_out_n_r));

/* File: verif/tmr_conv_model.sv */
module tmr_conv_model (
  input  logic        clk,          // core clock
  input  logic        reset,        // async reset
  input  logic        conv_start_r, // start request
  input  logic [4:0]  lag,          // answer delay
  input  logic [7:0]  l_val,        // local value
  input  logic [10:0] r_val,        // remote value
  input  logic        o_val,        // open sensor
  output logic        conv_done,    // result strobe
  output logic [7:0]  local_meas,   // local result
  output logic [10:0] remote_meas,  // remote result
  output logic        remote_open   // open flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] cnt_r;
  // results hold only with the strobe; inverse otherwise so stale data cannot pass
  assign local_meas  = conv_done ? l_val : ~l_val;
  assign remote_meas = conv_done ? r_val : ~r_val;
  assign remote_open = conv_done ? o_val : ~o_val;
  // count down the conversion time and pulse once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r     <= 6'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt_r == 6'h01);
      if (conv_start_r) cnt_r <= {1'b0, lag} + 6'h02;
      else if (cnt_r != 6'h00) cnt_r <= cnt_r - 6'h01;
    end
  end
endmodule // tmr_conv_model

/* File: verif/tmr_regfile_bench.sv */
module tmr_regfile_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset, ptr_wr_stb, data_wr_stb, rd_stb, alert_resp_stb, standby_pin;
  logic [7:0] wr_byte, rd_byte_r, local_meas, l_val, rnd, s0;
  logic [7:0] starts = 8'h00;
  logic [10:0] remote_meas, r_val;
  logic conv_start_r, conv_done, remote_open, o_val, alarm_out_n_r, pend_r = 1'b0;
  logic [4:0] lag;
  logic [7:0] exp_q[$], adr_q[$];
  int n_errors = 0, checks_done = 0, seed = 1;
  logic [7:0] ra[15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                         8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19};
  logic [7:0] rv[15] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9,
                         8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // offset cases, only the second saturating: trim hi/lo, raw remote, expected hi/lo, expected status
  logic [7:0]  th[3] = '{8'h01, 8'h7f, 8'h80}, tl[3] = '{8'h20, 8'he0, 8'h00};
  logic [10:0] rm[3] = '{11'h0a0, 11'h3f0, 11'h000};
  logic [7:0]  eh[3] = '{8'h15, 8'h7f, 8'h80}, el[3] = '{8'h20, 8'he0, 8'h00};
  logic [7:0]  es[3] = '{8'h00, 8'h10, 8'h18};
  // limit cases: local, remote, open, status on first and second read
  logic [7:0]  fl[5] = '{8'h19, 8'h1a, 8'h18, 8'h19, 8'h19};
  logic [10:0] fr[5] = '{11'h0a0, 11'h0a1, 11'h09f, 11'h0a0, 11'h0a0};
  logic        fo[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0]  f1[5] = '{8'h08, 8'h50, 8'h78, 8'h2c, 8'h04};
  logic [7:0]  f2[5] = '{8'h00, 8'h50, 8'h28, 8'h04, 8'h00};

  tmr_regfile #(.FAST_PERIOD_CYC(16)) u_tmr_regfile (.clk(clk), .reset(reset),
    .ptr_wr_stb(ptr_wr_stb), .data_wr_stb(data_wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb),
    .rd_byte_r(rd_byte_r), .alert_resp_stb(alert_resp_stb), .standby_pin(standby_pin),
    .conv_start_r(conv_start_r), .conv_done(conv_done), .local_meas(local_meas),
    .remote_meas(remote_meas), .remote_open(remote_open), .alarm_out_n_r(alarm_out_n_r));
  tmr_conv_model u_tmr_conv_model (.clk(clk), .reset(reset), .conv_start_r(conv_start_r),
    .lag(lag), .l_val(l_val), .r_val(r_val), .o_val(o_val), .conv_done(conv_done),
    .local_meas(local_meas), .remote_meas(remote_meas), .remote_open(remote_open));

  always #5 clk = ~clk;
  // read answers land one edge after the strobe; each is matched to the oldest note
  always @(posedge clk) begin
    pend_r <= rd_stb;
    if (conv_start_r) starts <= starts + 8'h01;
  end
  always @(negedge clk) if (pend_r) check($sformatf("reg %h", adr_q.pop_front()), rd_byte_r,
    exp_q.pop_front());

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic dat);
    @(negedge clk) ptr_wr_stb = 1'b1;
    wr_byte = a;
    @(negedge clk) ptr_wr_stb = 1'b0;
    data_wr_stb = dat;
    wr_byte = d;
    @(negedge clk) data_wr_stb = 1'b0;
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    put(a, 8'h00, 1'b0);
    rd_stb = 1'b1;
    adr_q.push_back(a);
    exp_q.push_back(e);
    @(negedge clk) rd_stb = 1'b0;
  endtask
  // one-shot conversion; bsy nonzero also reads status while it runs
  task automatic conv(input logic [7:0] l, input logic [10:0] r, input logic o,
                      input logic [7:0] bsy);
    l_val = l;
    r_val = r;
    o_val = o;
    lag = 5'd20 + 5'($random(seed) & 7);
    put(8'h0f, 8'ha5, 1'b1);
    if (bsy !== 8'h00) get(8'h02, bsy);
    for (int i = 0; i < 60 && conv_done !== 1'b1; i++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {ptr_wr_stb, data_wr_stb, rd_stb, alert_resp_stb, o_val} = 5'h00;
    {wr_byte, l_val, r_val, lag} = 32'h0;
    standby_pin = 1'b1;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 15; i++) get(ra[i], rv[i]);
    put(8'h09, 8'h40, 1'b1);
    put(8'h00, 8'h55, 1'b1);
    get(8'h00, 8'h80);
    get(8'h03, 8'h40);
    put(8'h0a, 8'h07, 1'b1);
    get(8'h04, 8'h07);
    rnd = 8'($random(seed));
    put(8'h13, rnd, 1'b1);
    get(8'h13, rnd & 8'he0);
    put(8'h13, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      put(8'h11, th[i], 1'b1);
      put(8'h12, tl[i], 1'b1);
      conv(8'h19, rm[i], 1'b0, (i == 0) ? 8'h80 : 8'h00);
      get(8'h01, eh[i]);
      get(8'h10, el[i]);
      get(8'h00, 8'h19);
      get(8'h02, es[i]);
    end
    put(8'h11, 8'h00, 1'b1);
    put(8'h12, 8'h00, 1'b1);
    for (int i = 5; i < 9; i++) put(8'(i + 6), (i < 7) ? 8'h19 : 8'h14, 1'b1);
    for (int i = 0; i < 5; i++) begin
      conv(fl[i], fr[i], fo[i], 8'h00);
      get(8'h02, f1[i]);
      get(8'h02, f2[i]);
    end
    check("shot starts", starts, 8'h08);
    check("alarm", {7'h0, alarm_out_n_r}, 8'h00);
    put(8'h09, 8'hc0, 1'b1);
    @(negedge clk) check("masked", {7'h0, alarm_out_n_r}, 8'h01);
    put(8'h09, 8'h40, 1'b1);
    alert_resp_stb = 1'b1;
    @(negedge clk) alert_resp_stb = 1'b0;
    repeat (2) @(negedge clk);
    check("released", {7'h0, alarm_out_n_r}, 8'h01);
    standby_pin = 1'b0;
    put(8'h09, 8'h00, 1'b1);
    s0 = starts;
    repeat (200) @(negedge clk);
    check("pin starts", starts - s0, 8'h00);
    get(8'h01, 8'h14);
    standby_pin = 1'b1;
    repeat (200) @(negedge clk);
    check("run starts", {7'h0, starts != s0}, 8'h01);
    reset = 1'b1;
    @(negedge clk) reset = 1'b0;
    get(8'h03, 8'h00);
    get(8'h04, 8'h02);
    get(8'h11, 8'h00);
    give_verdict;
  end
  // cut a hang short well past the expected run length
  initial begin
    #100us;
    n_errors++;
    give_verdict;
  end
endmodule // tmr_regfile_bench
